// [src/cat_timer.sv]
// Center-aligned timer time base with clock source selection and APB registers
//
// Design decisions made here: the address map and the APB register port.
`include "cat_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cat_timer (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ti2Pin,
  input  wire logic                  etrPin,
  input  wire logic [`CAT_ITR_N-1:0] itrIn,
  output logic      [`CAT_CNT_W-1:0] counterValue,
  output logic                       countDown,
  output logic                       updateEvent,
  output logic                       triggerEvent
);

  localparam cat_pkg::cat_state_t RST_ST = '{
    dir:     cat_pkg::CAT_UP,
    arrPre:  `CAT_RST_ARR,
    arrAct:  `CAT_RST_ARR,
    default: '0
  };

  cat_pkg::cat_state_t stFf;
  cat_pkg::cat_state_t nxtSt;

  logic              acc;
  logic              wrDo;
  logic              hit;
  logic [31:0]       rdMux;
  logic              ugReq;
  logic              ti2Edge;
  logic              itrEdge;
  logic              etrEdge;
  logic              trgEdge;
  logic              clkPulse;
  logic              cntTick;
  logic              ovf;
  logic              unf;
  logic              uevNow;
  logic              urgeUp;
  cat_pkg::cat_word_t arrLoad;

  //----------------------------------------------------------------------------
  // Register read mux and decode
  //----------------------------------------------------------------------------
  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      `CAT_OFF_CTRL: begin
        rdMux[`CAT_CTRL_CEN]   = stFf.counter_enable_bit;
        rdMux[`CAT_CTRL_UPDATE_DISABLE]  = stFf.update_disable;
        rdMux[`CAT_CTRL_URS]   = stFf.update_request_source;
        rdMux[`CAT_CTRL_DIR]   = stFf.dir;
        rdMux[`CAT_CTRL_CMODE] = stFf.cmode;
        rdMux[`CAT_CTRL_RELOAD_PRELOAD_ENABLE]  = stFf.reload_preload_enable;
      end
      `CAT_OFF_SMODE: begin
        rdMux[`CAT_SMODE_SMS+:3] = stFf.slave_mode_select;
        rdMux[`CAT_SMODE_TS+:3]  = stFf.ts;
        rdMux[`CAT_SMODE_ECE]    = stFf.ece;
      end
      `CAT_OFF_STAT: begin
        rdMux[`CAT_STAT_UIF] = stFf.update_flag;
        rdMux[`CAT_STAT_TIF] = stFf.trigger_flag;
      end
      // Trigger bit always reads back zero
      `CAT_OFF_EVGEN: rdMux = 32'h0000_0000;
      `CAT_OFF_CHMODE: begin
        rdMux[`CAT_CHMODE_CHANNEL2_INPUT_SELECT+:2] = stFf.channel2_input_select;
        rdMux[`CAT_CHMODE_CHANNEL2_INPUT_FILTER+:4] = stFf.channel2_input_filter;
      end
      `CAT_OFF_CHEN:  rdMux[`CAT_CHEN_CHANNEL2_POLARITY] = stFf.channel2_polarity;
      `CAT_OFF_COUNT: rdMux[`CAT_CNT_W-1:0] = stFf.cnt;
      `CAT_OFF_PSC:   rdMux[`CAT_CNT_W-1:0] = stFf.psc;
      `CAT_OFF_ARR:   rdMux[`CAT_CNT_W-1:0] = stFf.arrPre; // [RULE_24]
      default:        hit = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------------
  always_comb begin
    nxtSt = stFf;
    acc   = psel && penable;
    wrDo  = acc && pwrite && stFf.pready;
    ugReq = 1'b0;

    // One wait state: pready rises in the second access cycle
    nxtSt.pready  = acc && !stFf.pready;
    nxtSt.pslverr = acc && !stFf.pready && !hit;
    if (acc && !stFf.pready) begin
      nxtSt.prdata = hit ? rdMux : 32'h0000_0000;
    end

    if (wrDo && hit) begin
      unique case (paddr)
        `CAT_OFF_CTRL: begin
          nxtSt.counter_enable_bit   = pwdata[`CAT_CTRL_CEN];
          nxtSt.update_disable  = pwdata[`CAT_CTRL_UPDATE_DISABLE];
          nxtSt.update_request_source   = pwdata[`CAT_CTRL_URS];
          nxtSt.cmode = pwdata[`CAT_CTRL_CMODE];
          nxtSt.reload_preload_enable  = pwdata[`CAT_CTRL_RELOAD_PRELOAD_ENABLE];
          if (!stFf.cmode) begin
            nxtSt.dir = cat_pkg::cat_dir_t'(pwdata[`CAT_CTRL_DIR]); // [RULE_02] [RULE_10]
          end
        end
        `CAT_OFF_SMODE: begin
          nxtSt.slave_mode_select = pwdata[`CAT_SMODE_SMS+:3];
          nxtSt.ts  = pwdata[`CAT_SMODE_TS+:3];
          nxtSt.ece = pwdata[`CAT_SMODE_ECE];
        end
        `CAT_OFF_STAT: begin
          // Write zero clears; hardware sets below override
          nxtSt.update_flag = stFf.update_flag & pwdata[`CAT_STAT_UIF];
          nxtSt.trigger_flag = stFf.trigger_flag & pwdata[`CAT_STAT_TIF];
        end
        `CAT_OFF_EVGEN: ugReq = pwdata[`CAT_EVGEN_UG]; // [RULE_10]
        `CAT_OFF_CHMODE: begin
          nxtSt.channel2_input_select = pwdata[`CAT_CHMODE_CHANNEL2_INPUT_SELECT+:2];
          nxtSt.channel2_input_filter = pwdata[`CAT_CHMODE_CHANNEL2_INPUT_FILTER+:4];
        end
        `CAT_OFF_CHEN:  nxtSt.channel2_polarity   = pwdata[`CAT_CHEN_CHANNEL2_POLARITY];
        `CAT_OFF_COUNT: nxtSt.cnt    = pwdata[`CAT_CNT_W-1:0]; // [RULE_20]
        `CAT_OFF_PSC:   nxtSt.psc    = pwdata[`CAT_CNT_W-1:0]; // [RULE_22]
        `CAT_OFF_ARR:   nxtSt.arrPre = pwdata[`CAT_CNT_W-1:0]; // [RULE_24]
        default: ;
      endcase
    end

    nxtSt.cntEn = stFf.counter_enable_bit; // [RULE_21]

    // Pin synchronisers, two stages each
    nxtSt.ti2S1   = ti2Pin; // [RULE_19]
    nxtSt.ti2S2   = stFf.ti2S1;
    nxtSt.etrS1   = etrPin;
    nxtSt.etrS2   = stFf.etrS1;
    nxtSt.etrPrev = stFf.etrS2;
    nxtSt.itrPrev = itrIn;

    // Filter: level accepted after channel2_input_filter consecutive differing samples
    nxtSt.filtPrev = stFf.filtLvl;
    if (stFf.channel2_input_filter == 4'h0) begin
      nxtSt.filtLvl = stFf.ti2S2; // [RULE_15]
      nxtSt.filtCnt = 4'h0;
    end else if (stFf.ti2S2 != stFf.filtLvl) begin
      if (stFf.filtCnt + 4'h1 >= stFf.channel2_input_filter) begin
        nxtSt.filtLvl = stFf.ti2S2; // [RULE_15]
        nxtSt.filtCnt = 4'h0;
      end else begin
        nxtSt.filtCnt = stFf.filtCnt + 4'h1;
      end
    end else begin
      nxtSt.filtCnt = 4'h0;
    end

    // Edge path bypasses any capture prescaler [RULE_17]
    ti2Edge = (stFf.channel2_input_select == `CAT_CHANNEL2_INPUT_SELECT_TI2) &&                     // [RULE_14]
              (stFf.channel2_polarity ? (stFf.filtPrev && !stFf.filtLvl)
                         : (!stFf.filtPrev && stFf.filtLvl));      // [RULE_16]
    itrEdge = !stFf.ts[2] && itrIn[stFf.ts[1:0]] && !stFf.itrPrev[stFf.ts[1:0]];
    etrEdge = stFf.etrS2 && !stFf.etrPrev;
    trgEdge = (stFf.ts == `CAT_TS_TI2) ? ti2Edge : itrEdge; // [RULE_13]

    // Clock source select [RULE_09]
    if (stFf.slave_mode_select == `CAT_SMS_EXT1) begin
      clkPulse = trgEdge; // [RULE_12]
    end else if (stFf.ece) begin
      clkPulse = etrEdge;
    end else begin
      clkPulse = 1'b1; // [RULE_11]
    end

    if (stFf.slave_mode_select != `CAT_SMS_OFF && trgEdge) begin
      nxtSt.trigger_flag = 1'b1; // [RULE_18]
    end
    nxtSt.trgEv = trgEdge;

    // Prescaler: divides by pscBuf + 1
    cntTick = 1'b0;
    if (stFf.cntEn && clkPulse) begin
      if (stFf.pscCnt >= stFf.pscBuf) begin
        nxtSt.pscCnt = `CAT_RST_WORD;
        cntTick      = 1'b1; // [RULE_22]
      end else begin
        nxtSt.pscCnt = stFf.pscCnt + 16'h0001;
      end
    end

    // New reload is used for the turn-around when an update will happen
    arrLoad = stFf.update_disable ? stFf.arrAct : stFf.arrPre; // [RULE_08]
    ovf     = 1'b0;
    unf     = 1'b0;
    urgeUp  = ({1'b0, stFf.cnt} + 17'h00001) >= {1'b0, stFf.arrAct};

    if (ugReq) begin
      nxtSt.cnt    = `CAT_RST_WORD; // [RULE_04]
      nxtSt.pscCnt = `CAT_RST_WORD; // [RULE_04]
      if (stFf.cmode) begin
        nxtSt.dir = cat_pkg::CAT_UP;
      end
    end else if (cntTick) begin
      if (stFf.cmode) begin
        if (stFf.dir == cat_pkg::CAT_UP) begin
          if (urgeUp) begin
            ovf       = 1'b1;
            nxtSt.cnt = arrLoad; // [RULE_01] [RULE_08]
            nxtSt.dir = cat_pkg::CAT_DOWN; // [RULE_02]
          end else begin
            nxtSt.cnt = stFf.cnt + 16'h0001;
          end
        end else begin
          if (stFf.cnt <= 16'h0001) begin
            unf       = 1'b1;
            nxtSt.cnt = `CAT_RST_WORD; // [RULE_01]
            nxtSt.dir = cat_pkg::CAT_UP; // [RULE_02]
          end else begin
            nxtSt.cnt = stFf.cnt - 16'h0001;
          end
        end
      end else if (stFf.dir == cat_pkg::CAT_UP) begin
        if (stFf.cnt >= stFf.arrAct) begin
          ovf       = 1'b1;
          nxtSt.cnt = `CAT_RST_WORD;
        end else begin
          nxtSt.cnt = stFf.cnt + 16'h0001;
        end
      end else begin
        if (stFf.cnt == `CAT_RST_WORD) begin
          unf       = 1'b1;
          nxtSt.cnt = arrLoad;
        end else begin
          nxtSt.cnt = stFf.cnt - 16'h0001;
        end
      end
    end

    uevNow = !stFf.update_disable && (ugReq || ovf || unf); // [RULE_03] [RULE_05]
    if (!stFf.reload_preload_enable) begin
      nxtSt.arrAct = stFf.arrPre; // [RULE_23]
    end
    if (uevNow) begin
      nxtSt.pscBuf = stFf.psc;    // [RULE_07]
      nxtSt.arrAct = stFf.arrPre; // [RULE_07] [RULE_23]
      if (ovf || unf || !stFf.update_request_source) begin
        nxtSt.update_flag = 1'b1; // [RULE_06] [RULE_07]
      end
    end
    nxtSt.update_event = uevNow;
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stFf <= RST_ST;
    end else if (ce) begin
      stFf <= nxtSt;
    end
  end

  assign prdata       = stFf.prdata;
  assign pready       = stFf.pready;
  assign pslverr      = stFf.pslverr;
  assign counterValue = stFf.cnt;
  assign countDown    = stFf.dir;
  assign updateEvent  = stFf.update_event;
  assign triggerEvent = stFf.trgEv;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  a_cen_lag: // [RULE_21]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && stFf.counter_enable_bit && !stFf.cntEn |=> stFf.cntEn)
    else $error("counter enable did not follow enable bit");

  a_ug_restart: // [RULE_04]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && ugReq |=> stFf.cnt == 16'h0000 && stFf.pscCnt == 16'h0000)
    else $error("software update did not restart counters");

  a_ovf_turn: // [RULE_01]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && stFf.cmode && !ugReq && cntTick && stFf.dir == cat_pkg::CAT_UP && urgeUp
    |=> stFf.dir == cat_pkg::CAT_DOWN && updateEvent == !$past(stFf.update_disable))
    else $error("overflow did not turn counter down");

  a_update_disable_quiet: // [RULE_05]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && stFf.update_disable |=> !updateEvent)
    else $error("update event while updates disabled");

  a_urs_silent: // [RULE_06]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && ugReq && stFf.update_request_source && !stFf.update_flag |=> !stFf.update_flag)
    else $error("software update set flag with source select on");

  a_arr_xfer: // [RULE_07]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && uevNow |=> stFf.arrAct == $past(stFf.arrPre) && stFf.pscBuf == $past(stFf.psc))
    else $error("preloads not transferred on update");

  a_dir_hold: // [RULE_02]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && stFf.cmode && !cntTick && !ugReq |=> $stable(stFf.dir))
    else $error("direction changed without counting");

  a_ext_edge: // [RULE_18]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && stFf.slave_mode_select == `CAT_SMS_EXT1 && trgEdge |=> stFf.trigger_flag ##0 triggerEvent)
    else $error("trigger edge did not set trigger flag");

  a_reload_preload_enable_off: // [RULE_23]
  assert property (@(posedge clk) disable iff (!resetn)
    ce && !stFf.reload_preload_enable |=> stFf.arrAct == $past(stFf.arrPre))
    else $error("reload not immediate with preload off");

  a_uev_cause: // [RULE_03]
  assert property (@(posedge clk) disable iff (!resetn)
    updateEvent |-> $past(ce) && !$past(stFf.update_disable))
    else $error("update event without enabled cause");

endmodule // cat_timer

`default_nettype wire

// [src/cat_regs.svh]
// Register map, field positions, reset values and timing counts of the timer
//------------------------------------------------------------------------------
// Function
// RULE_01 - Center mode counts 0 up to reload minus one, overflow, down to 1, underflow
// RULE_02 - Direction bit ignores software writes in center mode; hardware shows real direction
// RULE_03 - Center mode raises update on overflow, on underflow and on software trigger
// RULE_04 - Software update trigger restarts counter and prescaler counter from zero
// RULE_05 - Update disable blocks update events; counting continues on active reload value
// RULE_06 - Update source select makes software update leave update flag untouched
// RULE_07 - Update event copies prescaler and reload preloads; sets flag unless suppressed
// RULE_08 - On overflow update the new reload value is loaded before counter reload
// RULE_09 - Counter clock from internal clock, channel-2 pin, trigger pin or other timer
// RULE_10 - Slave mode off: control bits software only; update trigger self-clears
// RULE_11 - Slave mode off: prescaler clocked internally once enable bit is written one
// RULE_12 - Slave mode 111 is external clock mode 1: count on selected trigger edges
// RULE_13 - Trigger select 110 routes filtered channel-2 input to slave controller
// RULE_14 - Channel-2 input select 01 makes channel 2 detect edges on its pin
// RULE_15 - Four-bit channel-2 filter sets filter length; zero means no filtering
// RULE_16 - Channel-2 polarity zero selects rising edge as active edge
// RULE_17 - Capture prescaler never divides edges used as counter clock
// RULE_18 - External mode 1: each active edge advances counter once and sets trigger flag
// RULE_19 - External input resynchronised to internal clock, giving fixed tick latency
// RULE_20 - Counter, reload and prescaler registers are 16 bits, accessible while running
// RULE_21 - Internal counter enable follows the enable bit one clock later
// RULE_22 - Prescaler divides by 1 to 65536; new ratio applies at next update
// RULE_23 - Reload preload enable set: transfer only at updates; clear: immediate
// RULE_24 - Reload writes always hit preload copy; active copy changes only by transfer
//------------------------------------------------------------------------------
`ifndef CAT_REGS_SVH
`define CAT_REGS_SVH

`define CAT_CNT_W        16
`define CAT_ITR_N        4

`define CAT_OFF_CTRL     12'h000
`define CAT_OFF_SMODE    12'h008
`define CAT_OFF_STAT     12'h010
`define CAT_OFF_EVGEN    12'h014
`define CAT_OFF_CHMODE   12'h018
`define CAT_OFF_CHEN     12'h020
`define CAT_OFF_COUNT    12'h024
`define CAT_OFF_PSC      12'h028
`define CAT_OFF_ARR      12'h02c

`define CAT_CTRL_CEN     0
`define CAT_CTRL_UPDATE_DISABLE    1
`define CAT_CTRL_URS     2
`define CAT_CTRL_DIR     4
`define CAT_CTRL_CMODE   5
`define CAT_CTRL_RELOAD_PRELOAD_ENABLE    7
`define CAT_SMODE_SMS    0
`define CAT_SMODE_TS     4
`define CAT_SMODE_ECE    14
`define CAT_STAT_UIF     0
`define CAT_STAT_TIF     6
`define CAT_EVGEN_UG     0
`define CAT_CHMODE_CHANNEL2_INPUT_SELECT  8
`define CAT_CHMODE_CHANNEL2_INPUT_FILTER  12
`define CAT_CHEN_CHANNEL2_POLARITY    5

`define CAT_SMS_OFF      3'h0
`define CAT_SMS_EXT1     3'h7
`define CAT_TS_TI2       3'h6
`define CAT_CHANNEL2_INPUT_SELECT_TI2     2'h1
`define CAT_RST_ARR      16'hffff
`define CAT_RST_WORD     16'h0000
`define CAT_CEN_LAT      1

`endif

// [src/cat_pkg.sv]
// Types shared by the timer design
`include "cat_regs.svh"
package cat_pkg;
  typedef logic [`CAT_CNT_W-1:0] cat_word_t;

  typedef enum logic {
    CAT_UP   = 1'b0,
    CAT_DOWN = 1'b1
  } cat_dir_t;

  typedef struct packed {
    logic                 counter_enable_bit;
    logic                 update_disable;
    logic                 update_request_source;
    logic                 cmode;
    logic                 reload_preload_enable;
    cat_dir_t             dir;
    logic [2:0]           slave_mode_select;
    logic [2:0]           ts;
    logic                 ece;
    logic                 update_flag;
    logic                 trigger_flag;
    logic [1:0]           channel2_input_select;
    logic [3:0]           channel2_input_filter;
    logic                 channel2_polarity;
    cat_word_t            cnt;
    cat_word_t            psc;
    cat_word_t            pscBuf;
    cat_word_t            pscCnt;
    cat_word_t            arrPre;
    cat_word_t            arrAct;
    logic                 cntEn;
    logic                 ti2S1;
    logic                 ti2S2;
    logic                 etrS1;
    logic                 etrS2;
    logic                 etrPrev;
    logic                 filtLvl;
    logic                 filtPrev;
    logic [3:0]           filtCnt;
    logic [`CAT_ITR_N-1:0] itrPrev;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 update_event;
    logic                 trgEv;
  } cat_state_t;
endpackage

// [dv/cat_pin_model.sv]
// Far-side model of the timer's input pins and internal trigger lines
`timescale 1ns/1ps
`default_nettype none
`include "cat_regs.svh"

module cat_pin_model (
  input  wire logic                  clk,
  output logic                       ch2Pin,
  output logic                       extTrigPin,
  output logic      [`CAT_ITR_N-1:0] trigIn
);
  initial begin
    ch2Pin     = 1'b0;
    extTrigPin = 1'b0;
    trigIn     = '0;
  end

  //----------------------------------------
  // Level driver
  //----------------------------------------
  task automatic setLvl(input int src, input logic v);
    case (src)
      0: ch2Pin <= v;
      1: extTrigPin <= v;
      default: trigIn[0] <= v;
    endcase
  endtask

  // Source 0 channel-2 pin, 1 trigger pin, 2 first internal trigger
  task automatic pulse(input int src, input int hi, input int lo);
    int h;
    int l;
    // Levels shorter than two clocks could slip past the resynchroniser
    h = (hi < 2) ? 2 : hi;
    l = (lo < 2) ? 2 : lo;
    @(posedge clk);
    setLvl(src, 1'b1);
    repeat (h) @(posedge clk);
    setLvl(src, 1'b0);
    repeat (l) @(posedge clk);
  endtask
endmodule // cat_pin_model

`default_nettype wire

// [dv/center_aligned_timer_clock_select_bench.sv]
// Self-checking bench for the center-aligned timer and its clock sources
`timescale 1ns/1ps
`default_nettype none
`include "cat_regs.svh"

module center_aligned_timer_clock_select_bench;
  //----------------------------------------
  // Signals
  //----------------------------------------
  logic                  clk;
  logic                  resetn;
  logic                  ce;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  ch2Pin;
  logic                  extTrigPin;
  logic [`CAT_ITR_N-1:0] trigIn;
  logic [`CAT_CNT_W-1:0] counterValue;
  logic                  countDown;
  logic                  updateEvent;
  logic                  triggerEvent;
  int                    mismatches = 0;
  int                    total_checks = 0;
  int                    evCount = 0;
  int                    trCount = 0;
  logic [31:0]           rv;
  logic                  ev;
  logic [15:0]           v0;
  int                    g;
  int                    e0;
  int                    t;

  typedef struct {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } cat_row_t;

  cat_row_t rows[13] = '{
    '{1'b0, `CAT_OFF_COUNT, 32'h0, 32'h0, 1'b0},
    '{1'b0, `CAT_OFF_PSC, 32'h0, 32'h0, 1'b0},
    '{1'b0, `CAT_OFF_ARR, 32'h0, {16'h0, `CAT_RST_ARR}, 1'b0},
    '{1'b0, `CAT_OFF_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, `CAT_OFF_STAT, 32'h0, 32'h0, 1'b0},
    '{1'b1, `CAT_OFF_PSC, 32'h1234, 32'h0, 1'b0},
    '{1'b0, `CAT_OFF_PSC, 32'h0, 32'h1234, 1'b0},
    '{1'b1, `CAT_OFF_ARR, 32'hdead0007, 32'h0, 1'b0},
    '{1'b0, `CAT_OFF_ARR, 32'h0, 32'h7, 1'b0},
    '{1'b1, 12'h004, 32'h5, 32'h0, 1'b1},
    '{1'b0, 12'h004, 32'h0, 32'h0, 1'b1},
    '{1'b0, `CAT_OFF_EVGEN, 32'h0, 32'h0, 1'b0},
    '{1'b1, `CAT_OFF_PSC, 32'h0, 32'h0, 1'b0}
  };

  //----------------------------------------
  // Design and pin model
  //----------------------------------------
  cat_timer dut_u (
    .clk(clk), .resetn(resetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ti2Pin(ch2Pin), .etrPin(extTrigPin),
    .itrIn(trigIn), .counterValue(counterValue), .countDown(countDown),
    .updateEvent(updateEvent), .triggerEvent(triggerEvent)
  );

  cat_pin_model pinModel_u (
    .clk(clk), .ch2Pin(ch2Pin), .extTrigPin(extTrigPin), .trigIn(trigIn)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (updateEvent === 1'b1) evCount++;
    if (triggerEvent === 1'b1) trCount++;
  end

  //----------------------------------------
  // Bus and check tasks
  //----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check(32'h1, 32'h0, "bus answer missing");
  endtask

  task automatic wrReg(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, wd, d, e);
  endtask

  task automatic rdReg(input logic [11:0] addr, output logic [31:0] rd);
    logic e;
    apb(1'b0, addr, 32'h0, rd, e);
  endtask

  // Syncs on the counter leaving zero, then checks n counts of the center sequence
  task automatic runCenter(input int arr, input int n, output int evs);
    int k;
    int v;
    k = 0;
    while (counterValue === 16'h0 && k < 200) begin @(posedge clk); k++; end
    while (counterValue !== 16'h0 && k < 200) begin @(posedge clk); k++; end
    while (counterValue === 16'h0 && k < 200) begin @(posedge clk); k++; end
    if (k >= 200) check(32'h1, 32'h0, "center count stuck");
    for (int i = 1; i <= n; i++) begin
      if (i == 3) evs = evCount;
      v = ((i % (2 * arr)) <= arr) ? i % (2 * arr) : 2 * arr - i % (2 * arr);
      check({16'h0, counterValue}, 32'(v), "center count");
      if (v >= 2 && v <= arr - 2) check({31'h0, countDown}, 32'(i % (2 * arr) > arr), "direction");
      @(posedge clk);
    end
    evs = evCount - evs;
  endtask

  task automatic gap(output int gp);
    logic [15:0] v;
    gp = 0;
    v = counterValue;
    while (counterValue === v && gp < 20) begin @(posedge clk); gp++; end
    v = counterValue;
    gp = 0;
    do begin @(posedge clk); gp++; end while (counterValue === v && gp < 20);
  endtask

  //----------------------------------------
  // Scenarios
  //----------------------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rv, ev);
      if (!rows[i].wr) check(rv, rows[i].rdata, "register read");
      check({31'h0, ev}, {31'h0, rows[i].err}, "error response");
    end
    $display("register table done");
    wrReg(`CAT_OFF_ARR, 32'h6);
    // Direction bit written high too; it still lands, since center mode is only set by this same write
    wrReg(`CAT_OFF_CTRL, 32'h31);
    runCenter(6, 22, g);
    check(32'(g), 32'h3, "updates per window");
    wrReg(`CAT_OFF_CTRL, 32'ha3);
    wrReg(`CAT_OFF_ARR, 32'h4);
    runCenter(6, 12, g);
    check(32'(g), 32'h0, "updates while disabled");
    wrReg(`CAT_OFF_CTRL, 32'ha1);
    runCenter(4, 14, g);
    check(32'(g), 32'h3, "updates after reload change");
    $display("center counting done");
    wrReg(`CAT_OFF_CTRL, 32'ha4);
    wrReg(`CAT_OFF_STAT, 32'h0);
    e0 = evCount;
    wrReg(`CAT_OFF_EVGEN, 32'h1);
    rdReg(`CAT_OFF_COUNT, rv);
    check(rv, 32'h0, "restart by software");
    check(32'(evCount - e0), 32'h1, "software update");
    rdReg(`CAT_OFF_STAT, rv);
    check(rv & 32'h1, 32'h0, "flag kept clear");
    rdReg(`CAT_OFF_EVGEN, rv);
    check(rv, 32'h0, "trigger self clear");
    wrReg(`CAT_OFF_CTRL, 32'ha0);
    wrReg(`CAT_OFF_EVGEN, 32'h1);
    rdReg(`CAT_OFF_STAT, rv);
    check(rv & 32'h1, 32'h1, "flag set");
    wrReg(`CAT_OFF_CTRL, 32'h83);
    wrReg(`CAT_OFF_PSC, 32'h2);
    gap(g);
    check(32'(g), 32'h1, "old ratio kept");
    wrReg(`CAT_OFF_CTRL, 32'h81);
    wrReg(`CAT_OFF_EVGEN, 32'h1);
    gap(g);
    check(32'(g), 32'h3, "new ratio");
    wrReg(`CAT_OFF_PSC, 32'h0);
    wrReg(`CAT_OFF_EVGEN, 32'h1);
    $display("software update and prescaler done");
    wrReg(`CAT_OFF_CHMODE, 32'h100);
    wrReg(`CAT_OFF_CHEN, 32'h0);
    wrReg(`CAT_OFF_SMODE, 32'h67);
    wrReg(`CAT_OFF_CTRL, 32'h01);
    wrReg(`CAT_OFF_ARR, 32'h10);
    wrReg(`CAT_OFF_EVGEN, 32'h1);
    wrReg(`CAT_OFF_STAT, 32'h0);
    e0 = trCount;
    v0 = counterValue;
    t = 0;
    fork
      pinModel_u.pulse(0, 10, 8);
      do begin @(posedge clk); t++; end while (counterValue === v0 && t < 12);
    join
    // Window is wide to absorb sampling skew on the resynchronised pin
    check(32'(t - 1 >= 3 && t - 1 <= 7), 32'h1, "pin to tick latency");
    repeat (2) pinModel_u.pulse(0, 4, 4);
    rdReg(`CAT_OFF_COUNT, rv);
    check(rv, 32'h3, "edges counted");
    check(32'(trCount - e0), 32'h3, "trigger pulses");
    rdReg(`CAT_OFF_STAT, rv);
    check(rv & 32'h40, 32'h40, "trigger flag");
    wrReg(`CAT_OFF_CHMODE, 32'h4100);
    pinModel_u.pulse(0, 2, 8);
    pinModel_u.pulse(0, 10, 8);
    rdReg(`CAT_OFF_COUNT, rv);
    check(rv, 32'h4, "filtered edges");
    wrReg(`CAT_OFF_CHMODE, 32'h0);
    pinModel_u.pulse(0, 6, 6);
    rdReg(`CAT_OFF_COUNT, rv);
    check(rv, 32'h4, "channel not input");
    for (int s = 0; s < 2; s++) begin
      wrReg(`CAT_OFF_SMODE, (s == 0) ? 32'h0007 : 32'h4000);
      wrReg(`CAT_OFF_EVGEN, 32'h1);
      repeat (2) pinModel_u.pulse(2 - s, 3, 3);
      rdReg(`CAT_OFF_COUNT, rv);
      check(rv, 32'h2, "other clock source");
    end
    $display("clock sources done");
    wrReg(`CAT_OFF_SMODE, 32'h0);
    repeat (5) @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    check({16'h0, counterValue}, 32'h0, "count in reset");
    check({31'h0, countDown}, 32'h0, "direction in reset");
    @(posedge clk);
    resetn <= 1'b1;
    rdReg(`CAT_OFF_ARR, rv);
    check(rv, {16'h0, `CAT_RST_ARR}, "reload after reset");
    $display("mid-run reset done");
    conclude();
  end

  initial begin
    #200000;
    mismatches++;
    $display("wrong value at %0t ns: run did not finish", $time);
    conclude();
  end
endmodule // center_aligned_timer_clock_select_bench

`default_nettype wire
